// [rtl/nsw_cfg.svh]
// constants for the nibble swap and indexed operand block
`ifndef NSW_CFG_SVH
`define NSW_CFG_SVH
`define NSW_OPC_SWAP      6'h0E
`define NSW_OPC_POS       10
`define NSW_DEST_POS      9
`define NSW_ACC_POS       8
`define NSW_IDX_LIMIT     8'h5F
`define NSW_ACC_HI_BASE   8'h60
`define NSW_ACC_HI_BANK   4'hF
`define NSW_SYNC_RST      2'b00
`endif

// [rtl/nsw_pkg.sv]
// types for the nibble swap and indexed operand block
package nsw_pkg;
   typedef enum logic [1:0] {
      NSW_IDLE  = 2'b00,
      NSW_READ  = 2'b01,
      NSW_WRITE = 2'b10
   } nsw_state_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] word;
   } nsw_instr_t;

   typedef struct packed {
      logic        valid;
      logic        we;
      logic [11:0] addr;
      logic [7:0]  data;
   } nsw_mem_t;

   typedef struct packed {
      nsw_state_t  state;
      logic [11:0] addr;
      logic        dest_f;
      logic        is_swap;
      logic        indexed;
      logic        mem_re;
      logic        mem_we;
      logic [7:0]  wdata;
      logic        w_we;
      logic [7:0]  w_data;
      logic        done;
   } nsw_state_reg_t;
endpackage

// [rtl/nsw_core.sv]
// operand address resolver and nibble swap execution unit
//
// Function
// [RL1] swap result exchanges nibbles, flags untouched
// [RL2] opcode 001110 in top six bits
// [RL3] destination bit 0 to W, 1 to file
// [RL4] access bit 0 access bank, 1 bank register
// [RL5] extension off: operand is literal address
// [RL6] extension on, a=0, f<=5Fh: frame offset
// [RL7] above 5Fh or a=1 stays literal
// [RL8] indexing applies to all byte/bit instructions
// [RL9] zero frame pointer reproduces access bank
// [RL10] destination bit unchanged in indexed mode
// [RL11] extension enable is static configuration input
`timescale 1ns/1ps
`include "nsw_cfg.svh"
module nsw_core (
   input  wire logic              i_clock,
   input  wire logic              i_nrst,
   input  wire logic              i_ext_enable,
   input  wire nsw_pkg::nsw_instr_t i_instr,
   input  wire logic              i_has_access_bit,
   input  wire logic [3:0]        i_bank_select_register,
   input  wire logic [11:0]       i_stack_frame_pointer,
   input  wire logic [7:0]        i_mem_rdata,
   output nsw_pkg::nsw_mem_t      o_mem,
   output logic [11:0]            o_resolved_addr,
   output logic                   o_indexed,
   output logic                   o_w_we,
   output logic [7:0]             o_w_data,
   output logic                   o_busy,
   output logic                   o_done
);
   import nsw_pkg::*;

   // ==========================================================
   // reset release
   logic [1:0]     rst_sync_reg;
   logic           rst_n;
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_sync_reg <= `NSW_SYNC_RST;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // ==========================================================
   // operand address resolution
   logic [7:0]     f_field;
   logic           acc_bit;
   logic           swap_hit;
   logic           idx_hit;
   logic [11:0]    res_addr;
   assign f_field  = i_instr.word[7:0];
   assign acc_bit  = i_instr.word[`NSW_ACC_POS];
   assign swap_hit = (i_instr.word[15:`NSW_OPC_POS] == `NSW_OPC_SWAP); // RL2
   // enable read fresh per instruction, never latched
   assign idx_hit  = i_ext_enable && i_has_access_bit && !acc_bit
                     && (f_field <= `NSW_IDX_LIMIT); // RL11 RL8 RL6 RL7

   always_comb begin
      if (idx_hit) begin
         // no wrap guard: pointer near top wraps in 12 bits
         res_addr = i_stack_frame_pointer + {4'h0, f_field}; // RL6 RL9
      end else if (acc_bit) begin
         res_addr = {i_bank_select_register, f_field}; // RL4 RL5
      end else if (f_field < `NSW_ACC_HI_BASE) begin
         res_addr = {4'h0, f_field}; // RL4 RL5
      end else begin
         res_addr = {`NSW_ACC_HI_BANK, f_field}; // RL4 RL5
      end
   end

   // ==========================================================
   // nibble exchange, one slice per result bit
   logic [7:0]     swapped;
   for (genvar gi = 0; gi < 8; gi++) begin : g_swap
      assign swapped[gi] = i_mem_rdata[(gi + 4) % 8]; // RL1
   end

   // ==========================================================
   // execution sequencer
   nsw_state_reg_t st_reg;
   nsw_state_reg_t st_next;

   always_comb begin
      st_next        = st_reg;
      st_next.mem_re = 1'b0;
      st_next.mem_we = 1'b0;
      st_next.w_we   = 1'b0;
      st_next.done   = 1'b0;
      case (st_reg.state)
         NSW_IDLE: begin
            if (i_instr.valid) begin
               st_next.addr    = res_addr;
               st_next.indexed = idx_hit;
               st_next.is_swap = swap_hit;
               st_next.dest_f  = i_instr.word[`NSW_DEST_POS]; // RL10
               if (swap_hit) begin
                  st_next.mem_re = 1'b1;
                  st_next.state  = NSW_READ;
               end
            end
         end
         NSW_READ: begin
            // read data arrives one cycle after the read strobe
            st_next.state = NSW_WRITE;
         end
         NSW_WRITE: begin
            if (st_reg.dest_f) begin
               st_next.mem_we = 1'b1; // RL3
               st_next.wdata  = swapped; // RL1
            end else begin
               st_next.w_we   = 1'b1; // RL3
               st_next.w_data = swapped; // RL1
            end
            st_next.done  = 1'b1;
            st_next.state = NSW_IDLE;
         end
         default: begin
            st_next.state = NSW_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // outputs; no status flag port exists, flags stay untouched
   always_comb begin
      o_mem.valid = st_reg.mem_re | st_reg.mem_we;
      o_mem.we    = st_reg.mem_we;
      o_mem.addr  = st_reg.addr;
      o_mem.data  = st_reg.wdata;
   end
   assign o_resolved_addr = st_reg.addr;
   assign o_indexed       = st_reg.indexed;
   assign o_w_we          = st_reg.w_we;
   assign o_w_data        = st_reg.w_data;
   assign o_busy          = (st_reg.state != NSW_IDLE);
   assign o_done          = st_reg.done;
endmodule // nsw_core

// [bench/nsw_core_assertions.sv]
// checker for the nibble swap and indexed operand core
`timescale 1ns/1ps
module nsw_core_assertions (
   input wire logic                i_clock,
   input wire logic                i_nrst,
   input wire logic                i_ext_enable,
   input wire nsw_pkg::nsw_instr_t i_instr,
   input wire logic                i_has_access_bit,
   input wire logic [3:0]          i_bank_select_register,
   input wire logic [11:0]         i_stack_frame_pointer,
   input wire nsw_pkg::nsw_mem_t   o_mem,
   input wire logic [11:0]         o_resolved_addr,
   input wire logic                o_indexed,
   input wire logic                o_w_we,
   input wire logic                o_busy,
   input wire logic                o_done
);
   import nsw_pkg::*;
   wire [15:0] w   = i_instr.word;
   wire        acc = i_instr.valid && !o_busy;
   wire        sw  = acc && w[15:10] == 6'h0E;
   wire        ix  = i_ext_enable && i_has_access_bit && !w[8]
                     && w[7:0] <= 8'h5F;
   default clocking dc @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   property p_rd; sw |=> o_mem.valid && !o_mem.we; endproperty
   a_rd: assert property (p_rd) else $error("no read");
   property p_fw; sw && w[9] |-> ##3 o_done && o_mem.we && !o_w_we;
   endproperty
   a_fw: assert property (p_fw) else $error("no file write");
   property p_wr; sw && !w[9] |-> ##3 o_done && o_w_we && !o_mem.valid;
   endproperty
   a_wr: assert property (p_wr) else $error("no w write");
   property p_ns; acc && w[15:10] != 6'h0E |=> !o_busy; endproperty
   a_ns: assert property (p_ns) else $error("busy on other op");
   property p_ix; acc |=> o_indexed == $past(ix); endproperty
   a_ix: assert property (p_ix) else $error("mode wrong");
   property p_ad; acc && ix |=>
      o_resolved_addr == $past(i_stack_frame_pointer + w[7:0]); endproperty
   a_ad: assert property (p_ad) else $error("offset wrong");
   property p_bk; acc && w[8] |=>
      o_resolved_addr == $past({i_bank_select_register, w[7:0]}); endproperty
   a_bk: assert property (p_bk) else $error("bank wrong");
   property p_lt; acc && !w[8] && !ix |=>
      o_resolved_addr == $past({{4{w[7:0] > 8'h5F}}, w[7:0]}); endproperty
   a_lt: assert property (p_lt) else $error("literal wrong");
   c_ix: cover property (acc && ix);
   c_fw: cover property (sw && w[9]);
   c_wr: cover property (sw && !w[9]);
endmodule // nsw_core_assertions
bind nsw_core nsw_core_assertions i_chk (.*);

// [bench/nsw_mem_model.sv]
// data memory model behind the core's memory port
`timescale 1ns/1ps
module nsw_mem_model (
   input  wire nsw_pkg::nsw_mem_t i_mem,
   input  wire logic              i_clock,
   output logic [7:0]             o_rdata
);
   logic [7:0] mem [4096];
   initial begin
      o_rdata = 8'h00;
      for (int i = 0; i < 4096; i++)
         mem[i] = i[7:0] ^ i[11:4];
   end
   // read data lasts one cycle; then the line toggles so no stale hold
   always @(posedge i_clock) begin
      if (i_mem.valid && i_mem.we)
         mem[i_mem.addr] <= i_mem.data;
      o_rdata <= i_mem.valid && !i_mem.we ? mem[i_mem.addr] : ~o_rdata;
   end
endmodule // nsw_mem_model

// [bench/tb_nsw_core.sv]
// self-checking bench for the nibble swap and indexed operand core
`timescale 1ns/1ps
module tb_nsw_core;
   import nsw_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, ext = 1'b0, h = 1'b0;
   logic [3:0]  bank_select_register = 4'h0;
   logic [7:0]  rd, wd, f;
   logic [11:0] fsr = 12'h000, a, p, ea;
   logic [15:0] w;
   logic [21:0] e, q [$];
   logic [31:0] r = 32'hbac3_5e83;
   logic        wwe, idx, bsy, dne, ix;
   nsw_instr_t  ins = '0;
   nsw_mem_t    mem;
   int          error_cnt = 0, cmp_count = 0;
   always #50 clk = ~clk;
   nsw_core i_dut (.i_clock(clk), .i_nrst(nrst), .i_ext_enable(ext),
      .i_instr(ins), .i_has_access_bit(h), .i_bank_select_register(bank_select_register),
      .i_stack_frame_pointer(fsr), .i_mem_rdata(rd), .o_mem(mem),
      .o_resolved_addr(a), .o_indexed(idx), .o_w_we(wwe), .o_w_data(wd),
      .o_busy(bsy), .o_done(dne));
   nsw_mem_model i_mdl (.i_clock(clk), .i_mem(mem), .o_rdata(rd));
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic chk(string n, logic [11:0] s, logic [11:0] x);
      cmp_count++;
      if (s !== x) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic tally_and_finish;
      if (error_cnt == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ===================== stimulus
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      repeat (300) begin
         r = xs(r);
         f = r[17] ? (r[18] ? 8'h5F : 8'h60) : r[7:0];
         w = {r[16] ? 6'h0E : r[15:10], r[9:8], f};
         p = r[24] ? 12'h000 : r[31:20];
         ix = !w[8] && r[19] && (r[25] | r[16]) && f <= 8'h5F;
         if (w[8]) ea = {r[23:20], f};
         else if (ix) ea = p + f;
         else ea = {{4{f > 8'h5F}}, f};
         if (w[15:10] == 6'h0E)
            q.push_back({ix, w[9], ea, i_mdl.mem[ea][3:0],
                         i_mdl.mem[ea][7:4]});
         ext <= r[19];
         bank_select_register <= r[23:20];
         fsr <= p;
         h <= r[25] | r[16];
         ins <= '{1'b1, w};
         @(posedge clk);
         ins.valid <= 1'b0;
         repeat (4) @(posedge clk);
      end
      tally_and_finish();
   end
   initial begin
      #400_000;
      error_cnt++;
      tally_and_finish();
   end
   // ===================== result watcher
   always @(posedge clk) if (mem.valid && !mem.we) begin
      chk("busy", {11'h0, bsy}, 12'h001);
   end
   always @(posedge clk) if (mem.valid && mem.we || wwe) begin
      e = q.pop_front();
      chk("done", {11'h0, dne}, 12'h001);
      chk("indexed", {11'h0, idx}, {11'h0, e[21]});
      chk("dest", {11'h0, mem.we}, {11'h0, e[20]});
      chk("addr", a, e[19:8]);
      chk("data", {4'h0, mem.we ? mem.data : wd}, {4'h0, e[7:0]});
   end
endmodule // tb_nsw_core
